// File: logic/clk_gate_pkg.sv
// Constants and carrier types for the clock stop / power-down gating block.
// Assumes every generated clock reaches the block as a phase level on clk_sys.
// Operation
// - Free-running outputs ignore both the PCI stop pin and the PCI stop control bit.
// - PCI stop input is sampled on rising edges of the free PCI clock.
// - On PCI stop, PCI and stoppable free PCI clocks go low at next falling edge.
// - Then stoppable reference pair holds true high, or tristates, complement low.
// - PCI stop release, sampled on free PCI clock, restarts those clocks glitch-free.
// - PCI stop leaves processor, 66, 48 and crystal reference clocks running.
// - Processor stop input may be asserted at any time, asynchronously.
// - Processor stop holds stoppable processor pairs true high, complement low, or tristated.
// - Processor pairs resume glitch-free two to six processor periods after release.
// - Tristated processor pair is driven high promptly after processor stop release.
// - Power-down stops every clock before the oscillator turns off, restarts cleanly.
// - Power-down acts only after two consecutive complement rising edges see it low.
// - During power-down every single-ended clock goes low at its next falling edge.
// - Power-down holds pairs at complement falling edge; drive mode picks tristate legs.
// - After power-down release, stable clocks arrive within 1.8 ms.
// - With power-down tristate set, pair is driven high before clocking resumes.
// - Shared output carries the 66 MHz clock, or 48 MHz when selected.
// - Switching: low at 66 falling edge, at least 7.49 ns, then 48 rising edge.
// - Each processor pair and the reference pair have their own tristate choices.
// - A differential output with enable low is tristated regardless of other bits.
// - Each differential output has enable, power-down tri, stop tri, free-run bits.
// - Enabled output with both tristate bits low keeps its true leg driven; its complement leg still tristates in power-down.
// - Clearing PCI stop control bit stops outputs exactly like asserting the pin.
// - PCI stop released during resume delay lets reference pair run at delay end.

package clk_gate_pkg;

   localparam int unsigned CPU_N            = 3;
   localparam int unsigned PCI_N            = 7;
   localparam int unsigned FREE_PCI_CLOCK_N           = 3;
   localparam int unsigned C66_N            = 4;
   localparam int unsigned REF_N            = 2;

   localparam int unsigned SYS_CLK_KHZ      = 25000;
   localparam int unsigned PD_RESUME_US     = 1800;
   // strictly under the limit, so one cycle short of it
   localparam int unsigned PD_RESUME_CYC    = PD_RESUME_US * SYS_CLK_KHZ / 1000 - 1;
   localparam int unsigned SWITCH_LOW_PS    = 7490;
   localparam int unsigned SWITCH_LOW_CYC   =
      (SWITCH_LOW_PS * SYS_CLK_KHZ + 999999999) / 1000000000;
   localparam int unsigned CPU_RESUME_EDGES = 2;
   localparam int unsigned PD_CONFIRM_EDGES = 2;

   typedef enum logic [1:0] {
      SH_66      = 2'b00,
      SH_LOW_48  = 2'b01,
      SH_48      = 2'b10,
      SH_LOW_66  = 2'b11
   } shared_state_t;

   typedef struct packed {
      logic cpu;
      logic pci;
      logic c66;
      logic dot48;
      logic usb48;
      logic ref14;
   } src_phase_t;

   typedef struct packed {
      logic [CPU_N-1:0]  cpu_oe;
      logic [CPU_N-1:0]  cpu_pd_tri;
      logic [CPU_N-1:0]  cpu_stop_tri;
      logic [CPU_N-1:0]  cpu_free;
      logic              sref_oe;
      logic              sref_pd_tri;
      logic              diff_ref_halt_tristate_bit;
      logic              sref_free;
      logic              pci_stop_ctl;
      logic [PCI_N-1:0]  pci_oe;
      logic [FREE_PCI_CLOCK_N-1:0] free_pci_clock_oe;
      logic [FREE_PCI_CLOCK_N-1:0] free_pci_clock_stoppable;
      logic [C66_N-1:0]  c66_oe;
      logic              shared_oe;
      logic              shared_sel;
      logic              usb_oe;
      logic              dot_oe;
      logic [REF_N-1:0]  ref_oe;
   } clk_cfg_t;

   typedef struct packed {
      logic [PCI_N-1:0]  pci_clk;
      logic [FREE_PCI_CLOCK_N-1:0] free_pci_clock;
      logic [C66_N-1:0]  clk66_output;
      logic              shared_66_or_48_output;
      logic              usb48_clk;
      logic              dot_clock_48;
      logic [REF_N-1:0]  ref14_clk;
   } se_out_t;

   typedef struct packed {
      logic [CPU_N-1:0]  cpu_t;
      logic [CPU_N-1:0]  cpu_c;
      logic [CPU_N-1:0]  cpu_oe_t;
      logic [CPU_N-1:0]  cpu_oe_c;
      logic              sref_t;
      logic              sref_c;
      logic              sref_oe_t;
      logic              sref_oe_c;
   } diff_out_t;

endpackage

// File: logic/se_gate.sv
// Glitch-free gate for a group of single-ended clocks sharing one phase.
// Assumes ph is a clk_sys-synchronous phase level of the source clock.
`timescale 1ns/1ns
`default_nettype none

module se_gate
#(
   parameter int unsigned W = 1
)
(
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         nrst,
   // source and control
   input  wire logic         ph,
   input  wire logic [W-1:0] run,
   // gated clocks
   output var  logic [W-1:0] out_q,
   output var  logic [W-1:0] held_q
);

   logic [W-1:0] out_d;
   logic [W-1:0] held_d;

   // the hold only changes while the source is low: no runt high pulse
   always_comb
   begin
      held_d = ph ? held_q : ~run;
      out_d  = {W{ph}} & ~held_q;
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         out_q  <= '0;
         held_q <= '1;
      end
      else
      begin
         out_q  <= out_d;
         held_q <= held_d;
      end
   end

endmodule

`default_nettype wire

// File: logic/diff_gate.sv
// Glitch-free gate for a group of differential pairs sharing one phase.
// Assumes ph is the true-leg phase level, synchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none

module diff_gate
#(
   parameter int unsigned W = 1
)
(
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         nrst,
   // source and control
   input  wire logic         ph,
   input  wire logic [W-1:0] en,
   input  wire logic [W-1:0] hold,
   input  wire logic [W-1:0] tri_t,
   input  wire logic [W-1:0] tri_c,
   // pair outputs
   output var  logic [W-1:0] t_q,
   output var  logic [W-1:0] c_q,
   output var  logic [W-1:0] oe_t_q,
   output var  logic [W-1:0] oe_c_q,
   output var  logic [W-1:0] held_q
);

   logic [W-1:0] held_d;
   logic [W-1:0] t_d;
   logic [W-1:0] c_d;
   logic [W-1:0] oe_t_d;
   logic [W-1:0] oe_c_d;

   // hold changes only while true is high (complement falling), so the
   // stopped level true-high matches and no glitch shows
   always_comb
   begin
      held_d = ph ? hold : held_q;
      t_d    = held_q | {W{ph}};
      c_d    = ~held_q & {W{~ph}};
      oe_t_d = en & ~(tri_t & held_q);
      oe_c_d = en & ~(tri_c & held_q);
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         held_q <= '1;
         t_q    <= '1;
         c_q    <= '0;
         oe_t_q <= '0;
         oe_c_q <= '0;
      end
      else
      begin
         held_q <= held_d;
         t_q    <= t_d;
         c_q    <= c_d;
         oe_t_q <= oe_t_d;
         oe_c_q <= oe_c_d;
      end
   end

endmodule

`default_nettype wire

// File: logic/clock_stop_powerdown_gating.sv
// Output gating for the stop and power-down pins of the clock generator.
// Assumes the synthesizer delivers each clock as a clk_sys phase level and
// the chipset drives the three control pins asynchronously.
`timescale 1ns/1ns
`default_nettype none

module clock_stop_powerdown_gating
   import clk_gate_pkg::*;
#(
   parameter int unsigned PD_RESUME_CYCLES = PD_RESUME_CYC
)
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   // control pins, asynchronous, active low
   input  wire logic        pci_stop_n,
   input  wire logic        cpu_stop_n,
   input  wire logic        power_down_n,
   // source clock phases and configuration bits
   input  wire src_phase_t  phase,
   input  wire clk_cfg_t    cfg,
   // gated clocks
   output wire se_out_t     se_out,
   output wire diff_out_t   diff_out,
   // status
   output var  logic        osc_enable_q,
   output var  logic        pd_active_q,
   output var  logic        cpu_stop_q,
   output var  logic        pci_stop_q
);

   // pin synchronisers
   logic [2:0]          pin_meta_q;
   logic [2:0]          pin_sync_q;
   logic                pci_pin;
   logic                cpu_pin;
   logic                pd_pin;

   // phase history for edge detection
   logic                cpu_prev_q;
   logic                pci_prev_q;
   logic                c66_prev_q;
   logic                dot_prev_q;
   logic                cpu_rise;
   logic                cpu_c_rise;
   logic                pci_rise;
   logic                c66_rise;
   logic                dot_rise;

   // control state
   logic                pci_stop_d;
   logic                pci_latched_q;
   logic                pci_latched_d;
   logic                cpu_stop_d;
   logic [1:0]          cpu_cnt_q;
   logic [1:0]          cpu_cnt_d;
   logic                pd_active_d;
   logic [1:0]          pd_cnt_q;
   logic [1:0]          pd_cnt_d;
   logic [31:0]         resume_q;
   logic [31:0]         resume_d;
   logic                osc_enable_d;
   logic                pd_low;

   // shared output switch
   shared_state_t       sh_state_q;
   shared_state_t       sh_state_d;
   logic [2:0]          sh_cnt_q;
   logic [2:0]          sh_cnt_d;
   logic                shared_ph;

   // gate controls
   logic [PCI_N-1:0]    pci_run;
   logic [FREE_PCI_CLOCK_N-1:0]   free_pci_clock_run;
   logic [C66_N-1:0]    c66_run;
   logic [REF_N-1:0]    ref_run;
   logic                shared_run;
   logic                usb_run;
   logic                dot_run;
   logic [CPU_N-1:0]    cpu_hold;
   logic [CPU_N-1:0]    cpu_tri_t;
   logic [CPU_N-1:0]    cpu_tri_c;
   logic                sref_hold;
   logic                sref_tri_t;
   logic                sref_tri_c;
   logic                sref_stop_tri;

   // hold flags from the cells
   logic [PCI_N-1:0]    pci_held;
   logic [FREE_PCI_CLOCK_N-1:0]   free_pci_clock_held;
   logic [C66_N-1:0]    c66_held;
   logic [REF_N-1:0]    ref_held;
   logic                shared_held;
   logic                usb_held;
   logic                dot_held;
   logic [CPU_N-1:0]    cpu_held;
   logic                sref_held;
   logic                all_held;

   // ---------------------------------------------------------------
   // two flip-flops per pin; only the second stage is read
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         pin_meta_q <= 3'h7;
         pin_sync_q <= 3'h7;
      end
      else
      begin
         pin_meta_q <= {pci_stop_n, cpu_stop_n, power_down_n};
         pin_sync_q <= pin_meta_q;
      end
   end

   assign pci_pin = pin_sync_q[2];
   assign cpu_pin = pin_sync_q[1];
   assign pd_pin  = pin_sync_q[0];

   assign cpu_rise   = phase.cpu & ~cpu_prev_q;
   assign cpu_c_rise = ~phase.cpu & cpu_prev_q;
   assign pci_rise   = phase.pci & ~pci_prev_q;
   assign c66_rise   = phase.c66 & ~c66_prev_q;
   assign dot_rise   = phase.dot48 & ~dot_prev_q;
   assign pd_low     = pd_active_q & ~pd_pin;

   // ---------------------------------------------------------------
   // stop and power-down sequencing
   always_comb
   begin
      // pin and control bit act alike, sampled on free PCI rising edge
      pci_stop_d = pci_stop_q;
      if (pci_rise)
      begin
         pci_stop_d = ~pci_pin | ~cfg.pci_stop_ctl;
      end

      // the reference pair waits until the PCI clocks have gone low
      pci_latched_d = pci_stop_q & (pci_latched_q | ~phase.pci);

      // stop takes effect at once; release waits for processor edges
      cpu_stop_d = cpu_stop_q;
      cpu_cnt_d  = cpu_cnt_q;
      if (!cpu_pin)
      begin
         cpu_stop_d = 1'b1;
         cpu_cnt_d  = 2'h0;
      end
      else if (cpu_stop_q && cpu_rise)
      begin
         cpu_cnt_d = cpu_cnt_q + 2'h1;
         if (cpu_cnt_d == 2'(CPU_RESUME_EDGES))
         begin
            cpu_stop_d = 1'b0;
            cpu_cnt_d  = 2'h0;
         end
      end

      // power-down: confirm on complement edges, hold through resume delay
      pd_active_d = pd_active_q;
      pd_cnt_d    = pd_cnt_q;
      resume_d    = resume_q;
      if (!pd_pin)
      begin
         resume_d = 32'h0;
         if (!pd_active_q && cpu_c_rise)
         begin
            pd_cnt_d = pd_cnt_q + 2'h1;
            if (pd_cnt_d == 2'(PD_CONFIRM_EDGES))
            begin
               pd_active_d = 1'b1;
               pd_cnt_d    = 2'h0;
            end
         end
      end
      else
      begin
         pd_cnt_d = 2'h0;
         if (pd_active_q)
         begin
            resume_d = resume_q + 32'h1;
            if (resume_q == 32'(PD_RESUME_CYCLES))
            begin
               pd_active_d = 1'b0;
               resume_d    = 32'h0;
            end
         end
      end

      // oscillator goes off only once every output is parked
      osc_enable_d = ~(pd_low & all_held);
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         cpu_prev_q    <= 1'b0;
         pci_prev_q    <= 1'b0;
         c66_prev_q    <= 1'b0;
         dot_prev_q    <= 1'b0;
         pci_stop_q    <= 1'b0;
         pci_latched_q <= 1'b0;
         cpu_stop_q    <= 1'b0;
         cpu_cnt_q     <= 2'h0;
         pd_active_q   <= 1'b0;
         pd_cnt_q      <= 2'h0;
         resume_q      <= 32'h0;
         osc_enable_q  <= 1'b1;
      end
      else
      begin
         cpu_prev_q    <= phase.cpu;
         pci_prev_q    <= phase.pci;
         c66_prev_q    <= phase.c66;
         dot_prev_q    <= phase.dot48;
         pci_stop_q    <= pci_stop_d;
         pci_latched_q <= pci_latched_d;
         cpu_stop_q    <= cpu_stop_d;
         cpu_cnt_q     <= cpu_cnt_d;
         pd_active_q   <= pd_active_d;
         pd_cnt_q      <= pd_cnt_d;
         resume_q      <= resume_d;
         osc_enable_q  <= osc_enable_d;
      end
   end

   // ---------------------------------------------------------------
   // shared output: 66 by default, 48 when selected, low gap between
   always_comb
   begin
      sh_state_d = sh_state_q;
      sh_cnt_d   = sh_cnt_q;
      shared_ph  = 1'b0;
      case (sh_state_q)
         SH_66:
         begin
            shared_ph = phase.c66;
            if (cfg.shared_sel && !phase.c66)
            begin
               sh_state_d = SH_LOW_48;
               sh_cnt_d   = 3'h0;
            end
         end
         SH_LOW_48:
         begin
            if (sh_cnt_q < 3'(SWITCH_LOW_CYC))
            begin
               sh_cnt_d = sh_cnt_q + 3'h1;
            end
            else if (dot_rise)
            begin
               sh_state_d = SH_48;
               shared_ph  = 1'b1;
            end
         end
         SH_48:
         begin
            shared_ph = phase.dot48;
            if (!cfg.shared_sel && !phase.dot48)
            begin
               sh_state_d = SH_LOW_66;
               sh_cnt_d   = 3'h0;
            end
         end
         default:
         begin
            // same low gap on the way back, ended by a 66 rising edge
            if (sh_cnt_q < 3'(SWITCH_LOW_CYC))
            begin
               sh_cnt_d = sh_cnt_q + 3'h1;
            end
            else if (c66_rise)
            begin
               sh_state_d = SH_66;
               shared_ph  = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         sh_state_q <= SH_66;
         sh_cnt_q   <= 3'h0;
      end
      else
      begin
         sh_state_q <= sh_state_d;
         sh_cnt_q   <= sh_cnt_d;
      end
   end

   // ---------------------------------------------------------------
   // run and hold requests per output group
   always_comb
   begin
      pci_run    = cfg.pci_oe & ~{PCI_N{pci_stop_q | pd_active_q}};
      free_pci_clock_run   = cfg.free_pci_clock_oe & ~{FREE_PCI_CLOCK_N{pd_active_q}}
                 & ~(cfg.free_pci_clock_stoppable & {FREE_PCI_CLOCK_N{pci_stop_q}});
      // PCI stop is deliberately absent from these groups
      c66_run    = cfg.c66_oe & ~{C66_N{pd_active_q}};
      ref_run    = cfg.ref_oe & ~{REF_N{pd_active_q}};
      shared_run = cfg.shared_oe & ~pd_active_q;
      usb_run    = cfg.usb_oe & ~pd_active_q;
      dot_run    = cfg.dot_oe & ~pd_active_q;

      // tristate requests drop as soon as the pin releases, so the pair
      // is driven high while the hold still waits for its resume edges
      cpu_hold   = {CPU_N{pd_active_q}} | ({CPU_N{cpu_stop_q}} & ~cfg.cpu_free);
      cpu_tri_t  = ({CPU_N{pd_low}} & cfg.cpu_pd_tri)
                 | ({CPU_N{~cpu_pin}} & cfg.cpu_stop_tri & ~cfg.cpu_free);
      cpu_tri_c  = {CPU_N{pd_low}}
                 | ({CPU_N{~cpu_pin}} & cfg.cpu_stop_tri & ~cfg.cpu_free);

      sref_stop_tri = pci_latched_q & ~cfg.sref_free & cfg.diff_ref_halt_tristate_bit
                    & (~pci_pin | ~cfg.pci_stop_ctl);
      sref_hold  = pd_active_q | (pci_latched_q & ~cfg.sref_free);
      sref_tri_t = (pd_low & cfg.sref_pd_tri) | sref_stop_tri;
      sref_tri_c = pd_low | sref_stop_tri;

      all_held   = (&pci_held) & (&free_pci_clock_held) & (&c66_held) & (&ref_held)
                 & shared_held & usb_held & dot_held & (&cpu_held) & sref_held;
   end

   // ---------------------------------------------------------------
   // gate cells
   se_gate #(.W(PCI_N)) u_pci
   (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .ph      (phase.pci),
      .run     (pci_run),
      .out_q   (se_out.pci_clk),
      .held_q  (pci_held)
   );

   se_gate #(.W(FREE_PCI_CLOCK_N)) u_free_pci_clock
   (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .ph      (phase.pci),
      .run     (free_pci_clock_run),
      .out_q   (se_out.free_pci_clock),
      .held_q  (free_pci_clock_held)
   );

   se_gate #(.W(C66_N)) u_c66
   (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .ph      (phase.c66),
      .run     (c66_run),
      .out_q   (se_out.clk66_output),
      .held_q  (c66_held)
   );

   se_gate #(.W(1)) u_shared
   (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .ph      (shared_ph),
      .run     (shared_run),
      .out_q   (se_out.shared_66_or_48_output),
      .held_q  (shared_held)
   );

   se_gate #(.W(1)) u_usb
   (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .ph      (phase.usb48),
      .run     (usb_run),
      .out_q   (se_out.usb48_clk),
      .held_q  (usb_held)
   );

   se_gate #(.W(1)) u_dot
   (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .ph      (phase.dot48),
      .run     (dot_run),
      .out_q   (se_out.dot_clock_48),
      .held_q  (dot_held)
   );

   se_gate #(.W(REF_N)) u_ref
   (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .ph      (phase.ref14),
      .run     (ref_run),
      .out_q   (se_out.ref14_clk),
      .held_q  (ref_held)
   );

   diff_gate #(.W(CPU_N)) u_cpu
   (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .ph      (phase.cpu),
      .en      (cfg.cpu_oe),
      .hold    (cpu_hold),
      .tri_t   (cpu_tri_t),
      .tri_c   (cpu_tri_c),
      .t_q     (diff_out.cpu_t),
      .c_q     (diff_out.cpu_c),
      .oe_t_q  (diff_out.cpu_oe_t),
      .oe_c_q  (diff_out.cpu_oe_c),
      .held_q  (cpu_held)
   );

   // reference pair parks on processor edges so it meets the power-down timing
   diff_gate #(.W(1)) u_sref
   (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .ph      (phase.cpu),
      .en      (cfg.sref_oe),
      .hold    (sref_hold),
      .tri_t   (sref_tri_t),
      .tri_c   (sref_tri_c),
      .t_q     (diff_out.sref_t),
      .c_q     (diff_out.sref_c),
      .oe_t_q  (diff_out.sref_oe_t),
      .oe_c_q  (diff_out.sref_oe_c),
      .held_q  (sref_held)
   );

endmodule

`default_nettype wire

// File: verification/pm_ctrl_model.sv
// Chipset power-management side: drives the three stop pins.
// Assumes requests come from the bench; pins move just after a clock edge.
`timescale 1ns/1ns
`default_nettype none
module pm_ctrl_model
(
   // clock
   input  wire logic clk_sys,
   // requests, active high
   input  wire logic req_pci,
   input  wire logic req_cpu,
   input  wire logic req_pd,
   // pins, active low
   output var  logic pci_stop_n = 1'h1,
   output var  logic cpu_stop_n = 1'h1,
   output var  logic power_down_n = 1'h1
);
   // registered like a real chipset output, so no runt pulses
   // requests taken at the edge, so no race with the bench's own update
   always @(posedge clk_sys)
   begin
      pci_stop_n <= #1 !req_pci;
      cpu_stop_n <= #1 !req_cpu;
      power_down_n <= #1 !req_pd;
   end
endmodule
`default_nettype wire

// File: verification/clock_stop_powerdown_gating_monitor.sv
// Port assertions for the stop and power-down gating block.
// Assumes one clock, clk_sys, with async reset nrst.
`timescale 1ns/1ns
`default_nettype none
module clock_stop_powerdown_gating_monitor
   import clk_gate_pkg::*;
(
   // clock and reset
   input  wire logic      clk_sys,
   input  wire logic      nrst,
   // pins and config
   input  wire logic      cpu_stop_n,
   input  wire logic      power_down_n,
   input  wire clk_cfg_t  cfg,
   // outputs
   input  wire se_out_t   se_out,
   input  wire diff_out_t diff_out,
   input  wire logic      osc_enable_q,
   input  wire logic      pd_active_q,
   input  wire logic      cpu_stop_q,
   input  wire logic      pci_stop_q
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   a_pci_parked_low: assert property (pci_stop_q [*6] |-> se_out.pci_clk == '0)
      else $error("pci clocks not parked low");
   a_pd_two_edges: assert property ($rose(pd_active_q) |-> !$past(power_down_n, 4))
      else $error("power-down taken too early");
   a_osc_after_park: assert property (!osc_enable_q |-> pd_active_q && se_out == '0)
      else $error("oscillator off before clocks parked");
   a_cpu_stop_sync: assert property ($rose(cpu_stop_q) |-> !$past(cpu_stop_n, 3))
      else $error("processor stop without pin");
   a_stop_pair_hold: assert property ((cpu_stop_q && !pd_active_q && !cfg.cpu_free[0]
      && !cfg.cpu_stop_tri[0]) [*6] |-> diff_out.cpu_t[0] && !diff_out.cpu_c[0])
      else $error("stopped pair not true high");
   a_stop_pair_tri: assert property ((cpu_stop_q && !pd_active_q && !cfg.cpu_free[1]
      && cfg.cpu_stop_tri[1] && !cpu_stop_n) [*6] |-> !diff_out.cpu_oe_t[1])
      else $error("stopped pair not tristated");
   a_disabled_tri: assert property (!cfg.cpu_oe[2] |=> !diff_out.cpu_oe_t[2]
      && !diff_out.cpu_oe_c[2])
      else $error("disabled pair driven");
   a_never_tri: assert property (cfg.cpu_oe[0] && !cfg.cpu_stop_tri[0] && !cfg.cpu_pd_tri[0]
      |=> diff_out.cpu_oe_t[0])
      else $error("driven pair tristated");
   cover property ($rose(pd_active_q));
   cover property ($rose(cpu_stop_q));
   cover property ($fell(pci_stop_q));
endmodule
bind clock_stop_powerdown_gating clock_stop_powerdown_gating_monitor u_mon (.clk_sys(clk_sys),
   .nrst(nrst), .cpu_stop_n(cpu_stop_n), .power_down_n(power_down_n), .cfg(cfg),
   .se_out(se_out), .diff_out(diff_out), .osc_enable_q(osc_enable_q),
   .pd_active_q(pd_active_q), .cpu_stop_q(cpu_stop_q), .pci_stop_q(pci_stop_q));
`default_nettype wire

// File: verification/clock_stop_powerdown_gating_tb.sv
// Self-checking bench for the gating block with a pin-driving partner.
// Assumes phases are made here from a counter; resume delay shortened to 20.
`timescale 1ns/1ns
`default_nettype none
module clock_stop_powerdown_gating_tb;
   import clk_gate_pkg::*;
   logic       clk_sys, nrst, req_pci, req_cpu, req_pd, osc_enable_q;
   logic       pd_active_q, cpu_stop_q, pci_stop_q;
   wire logic  pci_stop_n, cpu_stop_n, power_down_n;
   src_phase_t phase;
   clk_cfg_t   cfg;
   se_out_t    se_out, s0, s1, s2;
   diff_out_t  diff_out, d0, d1;
   logic [3:0] cnt;
   int         fails, comparisons;
   pm_ctrl_model u_pm_ctrl_model (.clk_sys(clk_sys), .req_pci(req_pci), .req_cpu(req_cpu),
      .req_pd(req_pd), .pci_stop_n(pci_stop_n), .cpu_stop_n(cpu_stop_n),
      .power_down_n(power_down_n));
   clock_stop_powerdown_gating #(.PD_RESUME_CYCLES(20)) u_clock_stop_powerdown_gating (
      .clk_sys(clk_sys), .nrst(nrst), .pci_stop_n(pci_stop_n), .cpu_stop_n(cpu_stop_n),
      .power_down_n(power_down_n), .phase(phase), .cfg(cfg), .se_out(se_out),
      .diff_out(diff_out), .osc_enable_q(osc_enable_q), .pd_active_q(pd_active_q),
      .cpu_stop_q(cpu_stop_q), .pci_stop_q(pci_stop_q));
   initial
   begin
      clk_sys = 1'h0;
      forever #20 clk_sys = ~clk_sys;
   end
   // cpu and 66 toggle every cycle, pci and dot every two
   always @(posedge clk_sys)
   begin
      #1;
      cnt = cnt + 4'h1;
      phase = {cnt[0], cnt[1], cnt[0], cnt[1], cnt[2], cnt[2]};
   end
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic smp;
      s0 = se_out;
      d0 = diff_out;
      wt(1);
      s1 = se_out;
      d1 = diff_out;
      wt(1);
      s2 = se_out;
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic t_pci;
      req_pci = 1'h1;
      wt(12);
      smp();
      chk(s0.pci_clk | s2.pci_clk, 0);
      chk(s0.free_pci_clock[2:1], 0);
      chk(s0.free_pci_clock[0] ^ s2.free_pci_clock[0], 1);
      chk(d0.cpu_t ^ d1.cpu_t, 3'h7);
      chk({d0.sref_t, d0.sref_c, d1.sref_t}, 3'h5);
      req_pci = 1'h0;
      wt(12);
      smp();
      chk(s0.pci_clk ^ s2.pci_clk, 7'h7F);
      cfg.pci_stop_ctl = 1'h0;
      cfg.diff_ref_halt_tristate_bit = 1'h1;
      wt(12);
      smp();
      chk(s0.pci_clk | s2.pci_clk, 0);
      chk({d0.sref_oe_t, d0.sref_oe_c, d0.sref_c}, 0);
      cfg.pci_stop_ctl = 1'h1;
      cfg.diff_ref_halt_tristate_bit = 1'h0;
      wt(12);
      $display("pci stop test done");
   endtask
   task automatic t_cpu;
      cfg.cpu_stop_tri = 3'h2;
      cfg.cpu_free = 3'h4;
      req_cpu = 1'h1;
      wt(10);
      smp();
      chk({d0.cpu_t[0], d0.cpu_c[0], d1.cpu_t[0], d1.cpu_c[0]}, 4'hA);
      chk({d0.cpu_oe_t[1], d0.cpu_oe_c[1]}, 0);
      chk(d0.cpu_t[2] ^ d1.cpu_t[2], 1);
      req_cpu = 1'h0;
      wt(4);
      chk({diff_out.cpu_oe_t[1], diff_out.cpu_t[1]}, 2'h3);
      wt(11);
      smp();
      chk(d0.cpu_t ^ d1.cpu_t, 3'h7);
      cfg.cpu_stop_tri = 3'h0;
      cfg.cpu_free = 3'h0;
      $display("cpu stop test done");
   endtask
   task automatic t_pd;
      cfg.cpu_pd_tri = 3'h1;
      req_pd = 1'h1;
      wt(20);
      smp();
      chk(s0 | s1, 0);
      chk(osc_enable_q, 0);
      chk({d0.cpu_t[1], d0.cpu_oe_t[1], d0.cpu_oe_c[1]}, 3'h6);
      chk({d0.cpu_oe_t[0], d0.cpu_oe_c[0]}, 0);
      req_pd = 1'h0;
      wt(8);
      chk({diff_out.cpu_t[0], diff_out.cpu_oe_t[0]}, 2'h3);
      wt(24);
      smp();
      chk(s0.pci_clk ^ s2.pci_clk, 7'h7F);
      chk(osc_enable_q, 1);
      cfg.cpu_pd_tri = 3'h0;
      cfg.cpu_oe[2] = 1'h0;
      wt(2);
      chk({diff_out.cpu_oe_t[2], diff_out.cpu_oe_c[2]}, 0);
      cfg.cpu_oe[2] = 1'h1;
      $display("power-down test done");
   endtask
   task automatic t_shared;
      cfg.shared_sel = 1'h1;
      wt(20);
      smp();
      chk(s0.shared_66_or_48_output ^ s2.shared_66_or_48_output, 1);
      cfg.shared_sel = 1'h0;
      wt(20);
      smp();
      chk(s0.shared_66_or_48_output ^ s1.shared_66_or_48_output, 1);
      $display("shared output test done");
   endtask
   initial
   begin
      nrst = 1'h0;
      {req_pci, req_cpu, req_pd} = 3'h0;
      cnt = 4'h0;
      phase = '0;
      cfg = '1;
      {cfg.cpu_pd_tri, cfg.cpu_stop_tri, cfg.cpu_free} = '0;
      {cfg.sref_pd_tri, cfg.diff_ref_halt_tristate_bit, cfg.sref_free} = 3'h0;
      cfg.free_pci_clock_stoppable = 3'h6;
      cfg.shared_sel = 1'h0;
      wt(3);
      nrst = 1'h1;
      wt(4);
      t_pci();
      t_cpu();
      t_pd();
      t_shared();
      final_report();
   end
   // tests need about 190 cycles
   initial
   begin
      repeat (2000) @(posedge clk_sys);
      fails++;
      final_report();
   end
endmodule
`default_nettype wire
